//--- inc/adc_ctrl_pkg.sv
// Shared constants for the converter select, update and sleep-start control
package adc_ctrl_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] OFS_SELECT = 4'h0;
	localparam logic [3:0] OFS_CONTROL = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_RESULT_LO = 4'h3;
	localparam logic [3:0] OFS_RESULT_HI = 4'h4;
	localparam logic [3:0] OFS_PRESCALE = 4'h5;
	localparam logic [3:0] OFS_ACTIVE_SEL = 4'h6;

	// Select register fields
	localparam int SEL_REF_HI = 7;
	localparam int SEL_REF_LO = 6;
	localparam int SEL_LEFT_ADJ = 5;
	localparam int SEL_MUX_HI = 4;
	localparam int SEL_DIFF_BIT = 4;
	localparam int SEL_DIFF_BIT2 = 3;

	// Control register fields
	localparam int CTL_ON = 7;
	localparam int CTL_START = 6;
	localparam int CTL_AUTO = 5;
	localparam int CTL_DONE = 4;
	localparam int CTL_IRQ_EN = 3;

	// Status register fields
	localparam int STS_BUSY = 0;
	localparam int STS_FIRST = 1;
	localparam int STS_SLEEP_CONV = 2;
	localparam int STS_IRQ = 3;

	// Reset values
	localparam logic [7:0] SELECT_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] PRESCALE_RST = 8'h01;

	// Conversion lengths in converter clocks
	localparam logic [4:0] CONV_NORMAL_CLKS = 5'h0D;
	localparam logic [4:0] CONV_FIRST_CLKS = 5'h19;

	// Full-scale code for an input at or above the reference
	localparam logic [9:0] CODE_FULL = 10'h3FF;

	// Conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_EDGE = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_e;

endpackage : adc_ctrl_pkg

//--- rtl/adc_prescaler.sv
// Converter clock prescaler producing a one-cycle rising-edge tick
`timescale 1ns/1ps
module adc_prescaler import adc_ctrl_pkg::*; #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [DIV_W-1:0] half_period,
	// Tick out
	output logic tick
);

	// Elaboration check on the divider width
	if (DIV_W < 2) begin : g_div_chk
		$error("adc_prescaler: DIV_W too small");
	end

	logic [DIV_W-1:0] cnt_r;
	logic phase_r;

	// Count half periods; held in reset while the converter is off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			phase_r <= 1'b0;
			tick <= 1'b0;
		end else if (!run || restart) begin
			cnt_r <= '0;
			phase_r <= 1'b0;
			tick <= 1'b0;
		end else if (cnt_r >= half_period) begin
			cnt_r <= '0;
			phase_r <= ~phase_r;
			tick <= ~phase_r; // Rising edge of converter clock
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule : adc_prescaler

//--- rtl/adc_select_update_sleep_ctrl.sv
// Converter control: selection buffering, conversion sequencing, sleep start
//
// Overview of operation
// [R1] With auto-trigger and enable set, a trigger may start conversion any cycle; the code takes a trigger only while ST_IDLE.
// [R2] Software changes selection only while idle, after trigger, or before flag clear.
// [R3] Selection written under safe conditions applies from the next conversion.
// [R4] Software waits 125 us or discards results after new differential channel.
// [R5] Same settling wait after reference select change before differential conversion.
// [R6] Single mode: select channel before start; change one converter clock later.
// [R7] Free running restarts at completion; new channel shows from second result.
// [R8] Software ignores the first result after switching to a gain channel.
// [R9] Software discards the first result after a reference switch.
// [R10] With external reference on the pin, software never picks internal references.
// [R11] Before sleep start: enabled, idle, single mode, completion interrupt on.
// [R12] Entering idle or noise-reduction sleep starts a conversion once CPU halts.
// [R13] Completion interrupt wakes the CPU when nothing else came first.
// [R14] Another wake first: completion request still raised at conversion end.
// [R15] Converter stays powered in other sleep states; only enable turns it off.
// [R16] Software toggles enable after such sleep for a valid differential result.
// [R17] Digital outputs on converter pins stay still during a conversion.
// [R18] Single-ended input above reference yields full-scale ten-bit code.
// [R19] Selection buffer follows writes, freezes at start, resumes in last clock.
// [R20] Start bit written: conversion begins on next converter clock rising edge.
// [R21] Completion stores result, sets flag, clears start bit in single mode.
// [R22] Sleep-started conversion reads start bit as one until completion.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module adc_select_update_sleep_ctrl import adc_ctrl_pkg::*; #(
	parameter int DATA_W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	// Trigger and sleep inputs
	input wire logic trigger_pulse,
	input wire logic sleep_enter,
	input wire logic sleep_adc_mode,
	input wire logic cpu_halted,
	// Analog core
	input wire logic [DATA_W-1:0] core_result,
	input wire logic core_over_ref,
	output logic [7:0] core_select,
	output logic core_sample,
	output logic core_power,
	// Interrupt request and wake
	output logic conv_irq,
	output logic cpu_wake
);

	if (DATA_W != 10) begin : g_width_chk
		$error("adc_select_update_sleep_ctrl: DATA_W must be 10");
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] input_ref_select_reg;
	logic [7:0] prescale_r;
	logic converter_on, conv_start_bit, auto_trigger_on, conv_done_flag, irq_en_r;
	logic [DATA_W-1:0] result_r;
	logic first_r, sleep_conv_r, sleep_armed_r;
	conv_state_e state_r;
	logic [4:0] clk_cnt_r;
	logic [4:0] conv_len_r;
	logic tick;
	logic last_clk, done_evt, start_req, trig_start, sleep_start;
	logic [9:0] adj_res;
	logic wr_sel, wr_ctl;

	assign wr_sel = wr_stb && addr == OFS_SELECT;
	assign wr_ctl = wr_stb && addr == OFS_CONTROL;

	// Prescaler restarts on an auto trigger for a fixed trigger delay
	adc_prescaler #(.DIV_W(8)) u_presc (
		.clk(clk),
		.rst(rst),
		.run(converter_on),
		.restart(trig_start),
		.half_period(prescale_r),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Start and completion decode
	// ----------------------------------------------------------------
	assign trig_start = converter_on && auto_trigger_on && trigger_pulse
		&& state_r == ST_IDLE; // R1
	assign sleep_start = converter_on && sleep_armed_r && cpu_halted
		&& state_r == ST_IDLE; // R12
	assign start_req = conv_start_bit && state_r == ST_IDLE;
	assign last_clk = state_r == ST_CONVERT && clk_cnt_r == conv_len_r - 5'd1;
	assign done_evt = last_clk && tick;
	assign adj_res = core_over_ref ? CODE_FULL : core_result; // R18

	// Sleep entry arms a one-shot start; cleared when launched or on wake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_armed_r <= 1'b0;
		end else if (sleep_enter && sleep_adc_mode && converter_on) begin
			sleep_armed_r <= 1'b1; // R12
		end else if (sleep_start || !cpu_halted || !converter_on) begin
			sleep_armed_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			clk_cnt_r <= '0;
		end else if (!converter_on) begin
			state_r <= ST_IDLE;
			clk_cnt_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start_req || trig_start || sleep_start) begin
						state_r <= ST_WAIT_EDGE;
					end
				end
				ST_WAIT_EDGE: begin
					if (tick) begin
						state_r <= ST_CONVERT; // R20
						clk_cnt_r <= '0;
					end
				end
				ST_CONVERT: begin
					if (done_evt) begin
						// Free running restarts straight away
						state_r <= auto_trigger_on && conv_start_bit ? ST_CONVERT : ST_IDLE; // R7
						clk_cnt_r <= '0;
					end else if (tick) begin
						clk_cnt_r <= clk_cnt_r + 5'd1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Length loaded extended at enable, switched to normal at the first completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_len_r <= CONV_FIRST_CLKS;
			first_r <= 1'b1;
		end else if (!converter_on) begin
			conv_len_r <= CONV_FIRST_CLKS;
			first_r <= 1'b1; // R16
		end else if (done_evt) begin
			first_r <= 1'b0;
			conv_len_r <= CONV_NORMAL_CLKS;
		end
	end

	// ----------------------------------------------------------------
	// Selection buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_select <= SELECT_RST;
		end else if (state_r != ST_CONVERT || last_clk) begin
			core_select <= input_ref_select_reg; // R19 R3
		end
	end

	// Sample strobe at every conversion start, free-running restarts too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_sample <= 1'b0;
		end else begin
			core_sample <= converter_on && tick && (state_r == ST_WAIT_EDGE
				|| last_clk && auto_trigger_on && conv_start_bit); // R20 R7
		end
	end

	// Power follows the enable only; sleep states do not switch it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_power <= 1'b0;
		end else begin
			core_power <= converter_on; // R15
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			input_ref_select_reg <= SELECT_RST;
			prescale_r <= PRESCALE_RST;
		end else if (wr_sel) begin
			input_ref_select_reg <= wdata;
		end else if (wr_stb && addr == OFS_PRESCALE) begin
			prescale_r <= wdata;
		end
	end

	// Control bits; a trigger leaves start clear so it cannot free run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			converter_on <= CONTROL_RST[CTL_ON];
			auto_trigger_on <= CONTROL_RST[CTL_AUTO];
			irq_en_r <= CONTROL_RST[CTL_IRQ_EN];
			conv_start_bit <= CONTROL_RST[CTL_START];
		end else begin
			if (wr_ctl) begin
				converter_on <= wdata[CTL_ON];
				auto_trigger_on <= wdata[CTL_AUTO];
				irq_en_r <= wdata[CTL_IRQ_EN];
			end
			if (!converter_on && !(wr_ctl && wdata[CTL_ON])) begin
				conv_start_bit <= 1'b0;
			end else if (sleep_start) begin
				conv_start_bit <= 1'b1; // R22
			end else if (wr_ctl && wdata[CTL_START]) begin
				conv_start_bit <= 1'b1;
			end else if (done_evt && !auto_trigger_on) begin
				conv_start_bit <= 1'b0; // R21
			end
		end
	end

	// Done flag: set wins over a write-one clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_done_flag <= 1'b0;
		end else if (done_evt) begin
			conv_done_flag <= 1'b1; // R21 R14
		end else if (wr_ctl && wdata[CTL_DONE]) begin
			conv_done_flag <= 1'b0;
		end
	end

	// Result capture at completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_r <= '0;
			sleep_conv_r <= 1'b0;
		end else begin
			if (done_evt) begin
				result_r <= adj_res; // R21 R18
			end
			if (sleep_start) begin
				sleep_conv_r <= 1'b1;
			end else if (done_evt) begin
				sleep_conv_r <= 1'b0;
			end
		end
	end

	// Completion request and wake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_irq <= 1'b0;
			cpu_wake <= 1'b0;
		end else begin
			conv_irq <= conv_done_flag && irq_en_r; // R13 R14
			cpu_wake <= done_evt && irq_en_r && cpu_halted; // R13
		end
	end

	// ----------------------------------------------------------------
	// Read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			if (addr == OFS_SELECT) begin
				rdata <= input_ref_select_reg;
			end else if (addr == OFS_CONTROL) begin
				rdata <= {converter_on, conv_start_bit || state_r != ST_IDLE,
					auto_trigger_on, conv_done_flag, irq_en_r, 3'b000}; // R22
			end else if (addr == OFS_STATUS) begin
				rdata <= {4'h0, conv_irq, sleep_conv_r, first_r, state_r != ST_IDLE};
			end else if (addr == OFS_RESULT_LO) begin
				rdata <= input_ref_select_reg[SEL_LEFT_ADJ] ? {result_r[1:0], 6'h00}
					: result_r[7:0];
			end else if (addr == OFS_RESULT_HI) begin
				rdata <= input_ref_select_reg[SEL_LEFT_ADJ] ? result_r[9:2]
					: {6'h00, result_r[9:8]};
			end else if (addr == OFS_PRESCALE) begin
				rdata <= prescale_r;
			end else if (addr == OFS_ACTIVE_SEL) begin
				rdata <= core_select;
			end else begin
				rdata <= 8'h00;
			end
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule : adc_select_update_sleep_ctrl

//--- sim/adc_core_model.sv
// Behavioural analog core answering sample requests
`timescale 1ns/1ps
module adc_core_model (
	// Clock
	input wire logic clk,
	// Core side
	input wire logic core_sample,
	input wire logic [7:0] core_select,
	output logic [9:0] core_result
);
	// Result carries the channel caught at sample time
	initial core_result = 10'h155;
	always @(posedge clk) begin
		if (core_sample) begin
			core_result <= {2'b10, core_select};
		end
	end
endmodule : adc_core_model

//--- sim/adc_ctrl_properties.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module adc_ctrl_properties import adc_ctrl_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	// Core and wake side
	input wire logic [7:0] core_select,
	input wire logic core_sample,
	input wire logic core_power,
	input wire logic conv_irq,
	input wire logic cpu_wake
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_sel_follow: assert property (
		wr_stb && addr == OFS_SELECT && !core_power |-> ##2 core_select == $past(wdata, 2))
		else $error("Idle select buffer did not follow write");
	chk_sel_frozen: assert property (
		core_sample |=> $stable(core_select) [*8])
		else $error("Select buffer moved during conversion");
	chk_power_follows: assert property (
		wr_stb && addr == OFS_CONTROL |-> ##2 core_power == $past(wdata[CTL_ON], 2))
		else $error("Core power differs from enable bit");
	chk_power_gate: assert property (
		!core_power |-> !core_sample)
		else $error("Sample while converter off");
	chk_sample_space: assert property (
		core_sample |=> !core_sample [*4])
		else $error("Samples closer than one converter clock");
	chk_wake_pulse: assert property (
		cpu_wake |=> !cpu_wake)
		else $error("Wake longer than one cycle");
	chk_wake_irq: assert property (
		cpu_wake |-> ##[0:2] conv_irq)
		else $error("Wake without completion request");
	chk_irq_off: assert property (
		wr_stb && addr == OFS_CONTROL && !wdata[CTL_IRQ_EN] |-> ##2 !conv_irq)
		else $error("Request stays with interrupt disabled");
endmodule : adc_ctrl_properties

//--- sim/adc_select_update_sleep_ctrl_tb.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
module adc_select_update_sleep_ctrl_tb import adc_ctrl_pkg::*; ;
	logic clk, rst, wr_stb, rd_stb, trigger_pulse, sleep_enter, sleep_adc_mode, cpu_halted;
	logic core_over_ref, core_sample, core_power, conv_irq, cpu_wake;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, core_select, rv;
	logic [9:0] core_result;
	int fails, tests_run, n;
	logic [9:0] wakes;

	adc_select_update_sleep_ctrl u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .trigger_pulse(trigger_pulse),
		.sleep_enter(sleep_enter), .sleep_adc_mode(sleep_adc_mode), .cpu_halted(cpu_halted),
		.core_result(core_result), .core_over_ref(core_over_ref), .core_select(core_select),
		.core_sample(core_sample), .core_power(core_power), .conv_irq(conv_irq),
		.cpu_wake(cpu_wake));
	adc_core_model u_core (.clk(clk), .core_sample(core_sample), .core_select(core_select),
		.core_result(core_result));

	// -----------
	// Bus tasks
	// -----------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 rv = rdata;
	endtask : rd
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wait_done();
		rv = 8'h00;
		for (n = 0; n < 200 && rv[CTL_DONE] !== 1'b1; n++) rd(OFS_CONTROL);
		chk(rv[CTL_DONE], 1'b1);
	endtask : wait_done
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// -----------
	// Scenarios
	// -----------
	initial begin
		{rst, wr_stb, rd_stb, trigger_pulse, sleep_enter} = 5'h10;
		{sleep_adc_mode, cpu_halted, core_over_ref} = 3'h0;
		addr = 4'h0;
		wdata = 8'h00;
		fails = 0;
		tests_run = 0;
		wakes = 10'h000;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_SELECT); chk(rv, SELECT_RST);
		rd(OFS_PRESCALE); chk(rv, PRESCALE_RST);
		rd(4'hF); chk(rv, 8'h00);
		wr(OFS_SELECT, 8'h45);
		rd(OFS_ACTIVE_SEL); chk(rv, 8'h45);
		// Single conversion with a select change mid-way
		wr(OFS_CONTROL, 8'hC8);
		rd(OFS_CONTROL); chk(rv[CTL_START], 1'b1);
		repeat (8) @(posedge clk);
		wr(OFS_SELECT, 8'h46);
		rd(OFS_ACTIVE_SEL); chk(rv, 8'h45);
		wait_done();
		chk(rv[CTL_START], 1'b0);
		rd(OFS_RESULT_LO); chk(rv, 8'h45);
		rd(OFS_RESULT_HI); chk(rv, 8'h02);
		rd(OFS_ACTIVE_SEL); chk(rv, 8'h46);
		chk(conv_irq, 1'b1);
		// Triggered conversion of an over-range input
		wr(OFS_CONTROL, 8'hB8);
		core_over_ref <= 1'b1;
		trigger_pulse <= 1'b1;
		@(posedge clk);
		trigger_pulse <= 1'b0;
		wait_done();
		rd(OFS_RESULT_LO); chk(rv, 8'hFF);
		rd(OFS_RESULT_HI); chk(rv, 8'h03);
		// Sleep entry launches a conversion that wakes the core
		wr(OFS_CONTROL, 8'h98);
		core_over_ref <= 1'b0;
		sleep_adc_mode <= 1'b1;
		sleep_enter <= 1'b1;
		@(posedge clk);
		sleep_enter <= 1'b0;
		cpu_halted <= 1'b1;
		repeat (10) @(posedge clk);
		rd(OFS_CONTROL); chk(rv[CTL_START], 1'b1);
		for (n = 0; n < 400 && cpu_wake !== 1'b1; n++) @(negedge clk);
		chk(cpu_wake, 1'b1);
		@(posedge clk);
		cpu_halted <= 1'b0;
		rd(OFS_RESULT_LO); chk(rv, 8'h46);
		rd(OFS_STATUS); chk(rv, 8'h08);
		// Left-adjust select bit: the held result reads back shifted into the high byte
		wr(OFS_SELECT, 8'h66);
		rd(OFS_RESULT_HI); chk(rv, 8'h91);
		rd(OFS_RESULT_LO); chk(rv, 8'h80);
		// Another wake before completion: request still raised, no wake pulse
		wr(OFS_CONTROL, 8'h98);
		sleep_enter <= 1'b1;
		@(posedge clk);
		sleep_enter <= 1'b0;
		cpu_halted <= 1'b1;
		repeat (10) @(posedge clk);
		cpu_halted <= 1'b0;
		rd(OFS_STATUS); chk(rv, 8'h05);
		wait_done();
		chk(conv_irq, 1'b1);
		chk(wakes, 10'h001);
		// Free running: a channel written after completion shows one result late
		wr(OFS_SELECT, 8'h41);
		wr(OFS_CONTROL, 8'hF0);
		wait_done();
		wr(OFS_SELECT, 8'h42);
		wr(OFS_CONTROL, 8'hF0);
		wait_done();
		rd(OFS_RESULT_LO); chk(rv, 8'h41);
		wr(OFS_CONTROL, 8'hF0);
		wait_done();
		rd(OFS_RESULT_LO); chk(rv, 8'h42);
		// Disable drops power and the request
		wr(OFS_CONTROL, 8'h00);
		repeat (3) @(negedge clk);
		chk(core_power, 1'b0);
		chk(conv_irq, 1'b0);
		rd(OFS_STATUS); chk(rv, 8'h02);
		wr(OFS_PRESCALE, 8'h02);
		rd(OFS_PRESCALE); chk(rv, 8'h02);
		final_report();
	end

	// Count wake pulses away from the launching edge
	always @(negedge clk) begin
		if (cpu_wake === 1'b1) wakes <= wakes + 10'h001;
	end

	// Watchdog against a hung wait
	initial begin
		#(25 * 5000);
		fails++;
		final_report();
	end
endmodule : adc_select_update_sleep_ctrl_tb

bind adc_select_update_sleep_ctrl adc_ctrl_properties u_props (.clk(clk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .core_select(core_select),
	.core_sample(core_sample), .core_power(core_power), .conv_irq(conv_irq),
	.cpu_wake(cpu_wake));
